// ==== hdl/tptu_pkg.sv ====
// Package of constants and types for the three-phase PWM timing unit.
package tptu_pkg;

    // ==========================================================
    // Register map, word indices on the plain register port.
    localparam logic [3:0] TPTU_IDX_HALF_PERIOD = 4'h0;
    localparam logic [3:0] TPTU_IDX_DEAD_TIME   = 4'h1;
    localparam logic [3:0] TPTU_IDX_MIN_PULSE   = 4'h2;
    localparam logic [3:0] TPTU_IDX_SYNC_WIDTH  = 4'h3;
    localparam logic [3:0] TPTU_IDX_DUTY_A      = 4'h4;
    localparam logic [3:0] TPTU_IDX_DUTY_B      = 4'h5;
    localparam logic [3:0] TPTU_IDX_DUTY_C      = 4'h6;
    localparam logic [3:0] TPTU_IDX_MODE_CTRL   = 4'h7;
    localparam logic [3:0] TPTU_IDX_STATUS      = 4'h8;
    localparam logic [3:0] TPTU_IDX_OUT_CTRL    = 4'h9;

    // ==========================================================
    // Field positions and widths.
    localparam int TPTU_MODE_DOUBLE_BIT = 6;
    localparam int TPTU_STAT_HALF_BIT   = 3;
    localparam int TPTU_STAT_RUN_BIT    = 0;
    localparam int TPTU_DT_W            = 10;
    localparam int TPTU_SW_W            = 8;
    localparam int TPTU_OC_W            = 9;

    // ==========================================================
    // Values after reset, and the value of the duty-written flags once all three duties are written.
    localparam logic [7:0]  TPTU_SYNC_WIDTH_RST = 8'h27;
    localparam logic [15:0] TPTU_ZERO16         = 16'h0000;
    localparam logic [2:0]  TPTU_WRITTEN_ALL    = 3'h7;

    // ==========================================================
    // Clock: one tick is one clock cycle.
    localparam int TPTU_CLK_NS  = 8;
    localparam int TPTU_TICK_NS = 8;
    localparam int TPTU_TICK_CYCLES = (TPTU_TICK_NS + TPTU_CLK_NS - 1) / TPTU_CLK_NS;

    // Settings latched into the timing unit at each sync edge.
    typedef struct packed {
        logic [15:0] half_period;
        logic [9:0]  dead_time;
        logic [15:0] min_pulse;
        logic [7:0]  sync_width;
        logic [15:0] duty_a;
        logic [15:0] duty_b;
        logic [15:0] duty_c;
    } tptu_cfg_t;

    typedef enum logic {
        TPTU_FIRST_HALF,
        TPTU_SECOND_HALF
    } tptu_half_t;

endpackage : tptu_pkg

// ==== hdl/tptu_phase.sv ====
// One phase pair: edge placement, minimum pulse and dead time.
`timescale 1ns/1ns
`default_nettype none
module tptu_phase
    import tptu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic        second_half_i,
    input  wire logic [15:0] count_i,
    input  wire logic [15:0] half_period_i,
    input  wire logic [15:0] duty_i,
    input  wire logic [9:0]  dead_time_i,
    input  wire logic [15:0] min_pulse_i,
    output logic             high_o,
    output logic             low_o
);
    logic [16:0] edge_pos;
    logic [16:0] low_on;
    logic        raw_high;
    logic        ideal_high;
    logic        allow_high;
    logic        allow_low;
    logic [16:0] dt_ext;

    assign dt_ext   = {6'h00, dead_time_i, 1'b0};
    assign low_on   = {1'b0, half_period_i} - {1'b0, duty_i};

    // High centred on the half boundary; each edge moves inward by dead_time.
    always_comb begin
        edge_pos = {1'b0, half_period_i} - {1'b0, duty_i};
        if (second_half_i) begin
            ideal_high = {1'b0, count_i} < {1'b0, duty_i};
            raw_high   = ({1'b0, count_i} + {7'h00, dead_time_i}) < {1'b0, duty_i}; // RQ19
        end else begin
            ideal_high = {1'b0, count_i} >= edge_pos;
            raw_high   = {1'b0, count_i} >= (edge_pos + {7'h00, dead_time_i}); // RQ19
        end
    end

    // Suppress pulses shorter than the minimum pulse count.
    always_comb begin
        allow_high = ({1'b0, duty_i} > {7'h00, dead_time_i})
                   && ((duty_i - {6'h00, dead_time_i}) >= min_pulse_i); // RQ21
        allow_low  = (low_on > {7'h00, dead_time_i})
                   && ((low_on - {7'h00, dead_time_i}) >= {1'b0, min_pulse_i}); // RQ21
    end

    // Low side is the complement, held off inside the dead band.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            high_o <= 1'b0;
            low_o  <= 1'b0;
        end else if (!run_i) begin
            high_o <= 1'b0; // RQ20
            low_o  <= 1'b0; // RQ20
        end else begin
            high_o <= raw_high && allow_high; // RQ4
            low_o  <= !ideal_high && !(raw_high ^ ideal_high)
                      && (dt_ext == 17'h00000 ? 1'b1 : !near_edge(count_i))
                      && allow_low; // RQ23
        end
    end

    // True while the count lies within dead_time of the ideal edge on the low side.
    function automatic logic near_edge(input logic [15:0] c);
        logic [16:0] e;
        e = second_half_i ? {1'b0, duty_i} : edge_pos;
        if (second_half_i) begin
            near_edge = ({1'b0, c} >= e) && ({1'b0, c} < e + {7'h00, dead_time_i});
        end else begin
            near_edge = ({1'b0, c} < e) && ({1'b0, c} + {7'h00, dead_time_i} >= e);
        end
    endfunction : near_edge
endmodule : tptu_phase
`default_nettype wire

// ==== hdl/tptu_timing_unit.sv ====
// Top of the three-phase PWM timing unit with its register port.
//
// Summary of operation
// RQ1: One clock cycle is one tick.
// RQ2: Half-period register counts half a period.
// RQ3: Half-period register is 16 bits wide.
// RQ4: Dead time separates each pair's transitions.
// RQ5: Dead time equals register times two ticks.
// RQ6: Dead-time register is 10 bits wide.
// RQ7: Zero dead-time register gives no dead time.
// RQ8: Mode bit 6 selects single or double update.
// RQ9: Reset clears mode bit, single update default.
// RQ10: Start sync pulse starts period, loads settings.
// RQ11: Output enables latched at each sync edge.
// RQ12: Double mode adds midpoint sync and reload.
// RQ13: Status bit 3 shows second half; the code sets it in double mode only and keeps it at 0 in single mode.
// RQ14: Sync pulse lasts width register plus one.
// RQ15: Sync width register resets to 0x27.
// RQ16: Sync pulse output paces the converter.
// RQ17: Three 16-bit duty registers, one per pair.
// RQ18: Duty is high-side on-time per half.
// RQ19: Dead time moves every edge equally.
// RQ20: Nothing runs until period and duties written.
// RQ21: Pulses below minimum count are suppressed.
// RQ22: One counter per half sets centred edges.
// RQ23: Low side complements high, off in dead band.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module tptu_timing_unit
    import tptu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic      [2:0]  high_o,
    output logic      [2:0]  low_o,
    output logic      [8:0]  out_ctrl_o,
    output logic             sync_o,
    output logic             second_half_o
);
    // ==========================================================
    // Software-visible registers.
    logic [15:0] half_period;
    logic [9:0]  dead_time;
    logic [15:0] min_pulse;
    logic [7:0]  sync_width;
    logic [15:0] duty [3];
    logic        double_mode;
    logic [8:0]  out_ctrl;
    logic [2:0]  duty_written;
    logic        period_written;
    logic        run;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_period <= TPTU_ZERO16;
            dead_time   <= 10'h000;
            min_pulse   <= TPTU_ZERO16;
            sync_width  <= TPTU_SYNC_WIDTH_RST; // RQ15
            duty[0]     <= TPTU_ZERO16;
            duty[1]     <= TPTU_ZERO16;
            duty[2]     <= TPTU_ZERO16;
            double_mode <= 1'b0; // RQ9
            out_ctrl    <= 9'h000;
        end else if (wr_i) begin
            unique case (addr_i)
                TPTU_IDX_HALF_PERIOD: half_period <= wdata_i; // RQ3
                TPTU_IDX_DEAD_TIME:   dead_time   <= wdata_i[TPTU_DT_W-1:0]; // RQ6
                TPTU_IDX_MIN_PULSE:   min_pulse   <= wdata_i;
                TPTU_IDX_SYNC_WIDTH:  sync_width  <= wdata_i[TPTU_SW_W-1:0];
                TPTU_IDX_DUTY_A:      duty[0]     <= wdata_i; // RQ17
                TPTU_IDX_DUTY_B:      duty[1]     <= wdata_i; // RQ17
                TPTU_IDX_DUTY_C:      duty[2]     <= wdata_i; // RQ17
                TPTU_IDX_MODE_CTRL:   double_mode <= wdata_i[TPTU_MODE_DOUBLE_BIT]; // RQ8
                TPTU_IDX_OUT_CTRL:    out_ctrl    <= wdata_i[TPTU_OC_W-1:0];
                default: ;
            endcase
        end
    end

    // Counters stay disabled until the period and every duty have been written.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            period_written <= 1'b0;
            duty_written   <= 3'h0;
            run            <= 1'b0;
        end else begin
            if (wr_i && addr_i == TPTU_IDX_HALF_PERIOD) begin
                period_written <= 1'b1;
            end
            if (wr_i && addr_i == TPTU_IDX_DUTY_A) begin
                duty_written[0] <= 1'b1;
            end
            if (wr_i && addr_i == TPTU_IDX_DUTY_B) begin
                duty_written[1] <= 1'b1;
            end
            if (wr_i && addr_i == TPTU_IDX_DUTY_C) begin
                duty_written[2] <= 1'b1;
            end
            run <= period_written && (duty_written == TPTU_WRITTEN_ALL); // RQ20
        end
    end

    // ==========================================================
    // Read port, data one cycle after the strobe.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= TPTU_ZERO16;
        end else if (rd_i) begin
            unique case (addr_i)
                TPTU_IDX_HALF_PERIOD: rdata_o <= half_period;
                TPTU_IDX_DEAD_TIME:   rdata_o <= {6'h00, dead_time};
                TPTU_IDX_MIN_PULSE:   rdata_o <= min_pulse;
                TPTU_IDX_SYNC_WIDTH:  rdata_o <= {8'h00, sync_width};
                TPTU_IDX_DUTY_A:      rdata_o <= duty[0];
                TPTU_IDX_DUTY_B:      rdata_o <= duty[1];
                TPTU_IDX_DUTY_C:      rdata_o <= duty[2];
                TPTU_IDX_MODE_CTRL:   rdata_o <= {9'h000, double_mode, 6'h00};
                TPTU_IDX_STATUS:      rdata_o <= {12'h000, second_half_o, 2'h0, run}; // RQ13
                TPTU_IDX_OUT_CTRL:    rdata_o <= {7'h00, out_ctrl};
                default:              rdata_o <= TPTU_ZERO16;
            endcase
        end else begin
            rdata_o <= TPTU_ZERO16;
        end
    end

    // ==========================================================
    // Half-period counter and sync generation.
    tptu_cfg_t   cfg;
    tptu_half_t  half;
    logic [15:0] count;
    logic [8:0]  sync_left;
    logic        half_end;
    logic        load_edge;

    assign half_end  = run && (count + 16'h0001 >= cfg.half_period); // RQ2
    // A reload happens at every period start; in double mode also at the midpoint.
    assign load_edge = half_end && (half == TPTU_SECOND_HALF || double_mode); // RQ12

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= TPTU_ZERO16;
            half  <= TPTU_FIRST_HALF;
        end else if (!run) begin
            count <= TPTU_ZERO16;
            half  <= TPTU_FIRST_HALF;
        end else if (half_end) begin
            count <= TPTU_ZERO16; // RQ22
            half  <= (half == TPTU_FIRST_HALF) ? TPTU_SECOND_HALF : TPTU_FIRST_HALF;
        end else begin
            count <= count + 16'h0001; // RQ1
        end
    end

    // Settings follow the registers every cycle while run is low, and latch at every sync edge.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg        <= '0;
            out_ctrl_o <= 9'h000;
        end else if (!run || load_edge) begin
            cfg.half_period <= half_period; // RQ10
            cfg.dead_time   <= dead_time; // RQ5
            cfg.min_pulse   <= min_pulse;
            cfg.sync_width  <= sync_width;
            cfg.duty_a      <= duty[0];
            cfg.duty_b      <= duty[1];
            cfg.duty_c      <= duty[2];
            out_ctrl_o      <= out_ctrl; // RQ11
        end
    end

    // The first sync rises with the run flag, so that it opens a full period.
    logic start_sync;
    assign start_sync = (!run && period_written && duty_written == TPTU_WRITTEN_ALL)
                        || load_edge; // RQ10

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_left    <= 9'h000;
            sync_o       <= 1'b0;
        end else begin
            if (start_sync) begin
                sync_o    <= 1'b1; // RQ16
                sync_left <= {1'b0, sync_width}; // RQ14
            end else if (sync_left != 9'h000) begin
                sync_left <= sync_left - 9'h001;
            end else begin
                sync_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            second_half_o <= 1'b0;
        end else begin
            second_half_o <= run && double_mode
                             && ((half == TPTU_SECOND_HALF) != half_end); // RQ13
        end
    end

    // ==========================================================
    // Phase pairs.
    logic [15:0] duty_cfg [3];
    assign duty_cfg[0] = cfg.duty_a;
    assign duty_cfg[1] = cfg.duty_b;
    assign duty_cfg[2] = cfg.duty_c;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        tptu_phase u_phase (
            .clk_i         (clk_i),
            .rst_i         (rst_i),
            .run_i         (run),
            .second_half_i (half == TPTU_SECOND_HALF),
            .count_i       (count),
            .half_period_i (cfg.half_period),
            .duty_i        (duty_cfg[p]),
            .dead_time_i   (cfg.dead_time), // RQ7
            .min_pulse_i   (cfg.min_pulse),
            .high_o        (high_o[p]), // RQ18
            .low_o         (low_o[p])
        );
    end

    // ==========================================================
    // Checks.
    property p_no_run_no_out;
        @(posedge clk_i) disable iff (rst_i)
        !run |=> (high_o == 3'h0 && low_o == 3'h0);
    endproperty
    a_no_run_no_out: assert property (p_no_run_no_out) else $error("outputs active before run"); // RQ20

    property p_no_overlap;
        @(posedge clk_i) disable iff (rst_i)
        (high_o & low_o) == 3'h0;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("high and low both on"); // RQ23

    property p_sync_rise;
        @(posedge clk_i) disable iff (rst_i)
        load_edge |=> sync_o;
    endproperty
    a_sync_rise: assert property (p_sync_rise) else $error("sync missing at reload"); // RQ10

    property p_single_no_mid;
        @(posedge clk_i) disable iff (rst_i)
        (half_end && half == TPTU_FIRST_HALF && !double_mode) |-> !load_edge;
    endproperty
    a_single_no_mid: assert property (p_single_no_mid) else $error("midpoint reload in single"); // RQ8

    property p_double_mid;
        @(posedge clk_i) disable iff (rst_i)
        (half_end && half == TPTU_FIRST_HALF && double_mode) |-> load_edge;
    endproperty
    a_double_mid: assert property (p_double_mid) else $error("no midpoint reload"); // RQ12

    property p_half_status;
        @(posedge clk_i) disable iff (rst_i)
        (run && double_mode && half == TPTU_SECOND_HALF && !half_end) |=> second_half_o;
    endproperty
    a_half_status: assert property (p_half_status) else $error("status bit not set"); // RQ13

    property p_count_bound;
        @(posedge clk_i) disable iff (rst_i)
        (run && cfg.half_period != TPTU_ZERO16) |-> count < cfg.half_period;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("counter past half period"); // RQ2

    property p_oc_latch;
        @(posedge clk_i) disable iff (rst_i)
        (run && load_edge) |=> out_ctrl_o == $past(out_ctrl);
    endproperty
    a_oc_latch: assert property (p_oc_latch) else $error("output control not latched"); // RQ11

    property p_sync_width_rst;
        @(posedge clk_i) $fell(rst_i) |-> sync_width == TPTU_SYNC_WIDTH_RST;
    endproperty
    a_sync_width_rst: assert property (p_sync_width_rst) else $error("bad sync width reset"); // RQ15

    c_run: cover property (@(posedge clk_i) $rose(run));
    c_mid: cover property (@(posedge clk_i) load_edge && half == TPTU_FIRST_HALF);
    property p_count_step;
        @(posedge clk_i) disable iff (rst_i)
        (run && !half_end) |=> count == $past(count) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step"); // RQ1

    property p_half_toggle;
        @(posedge clk_i) disable iff (rst_i)
        half_end |=> (count == TPTU_ZERO16 && half != $past(half));
    endproperty
    a_half_toggle: assert property (p_half_toggle) else $error("half did not turn"); // RQ22

    property p_cfg_load;
        @(posedge clk_i) disable iff (rst_i)
        load_edge |=> (cfg.half_period == $past(half_period)
                       && cfg.dead_time == $past(dead_time));
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("settings not loaded"); // RQ10

    property p_hold_cfg;
        @(posedge clk_i) disable iff (rst_i)
        (run && !load_edge) |=> ($stable(cfg) && $stable(out_ctrl_o));
    endproperty
    a_hold_cfg: assert property (p_hold_cfg) else $error("settings moved between syncs"); // RQ11

    property p_sync_hold;
        @(posedge clk_i) disable iff (rst_i)
        (sync_o && sync_left != 9'h000) |=> sync_o;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync pulse too short"); // RQ14

    property p_sync_end;
        @(posedge clk_i) disable iff (rst_i)
        (sync_o && sync_left == 9'h000 && !start_sync) |=> !sync_o;
    endproperty
    a_sync_end: assert property (p_sync_end) else $error("sync pulse too long"); // RQ14

    property p_single_status;
        @(posedge clk_i) disable iff (rst_i)
        !double_mode |=> !second_half_o;
    endproperty
    a_single_status: assert property (p_single_status) else $error("status set in single"); // RQ13

    property p_dual_sync;
        @(posedge clk_i) disable iff (rst_i)
        (double_mode && half_end) |=> sync_o;
    endproperty
    a_dual_sync: assert property (p_dual_sync) else $error("no sync at half end"); // RQ16

    property p_run_writes;
        @(posedge clk_i) disable iff (rst_i)
        run |-> (period_written && duty_written == TPTU_WRITTEN_ALL);
    endproperty
    a_run_writes: assert property (p_run_writes) else $error("running before writes"); // RQ20

    c_sync: cover property (@(posedge clk_i) $fell(sync_o));
    c_zero_dt: cover property (@(posedge clk_i) run && cfg.dead_time == 10'h000);
    c_half: cover property (@(posedge clk_i) $rose(second_half_o));
endmodule : tptu_timing_unit
`default_nettype wire

// ==== verif/tptu_gate_model.sv ====
// Output stage model that measures gate timing between sync pulses.
`timescale 1ns/1ns
`default_nettype none
module tptu_gate_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] high_i,
    input  wire logic [2:0] low_i,
    input  wire logic       sync_i,
    output logic            meas_o,
    output int              per_o,
    output int              hi_o[3],
    output int              lo_o[3],
    output int              sw_o,
    output logic            shoot_o
);
    // ==========================================================
    // Counters, published at each sync rise (sw_o at each sync fall), one cycle late.
    logic sync_q;
    logic rise;
    int   per_c;
    int   sw_c;
    int   hi_c[3];
    int   lo_c[3];

    assign rise = sync_i & ~sync_q;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_q  <= 1'b0;
            meas_o  <= 1'b0;
            shoot_o <= 1'b0;
            per_c   <= 0;
            sw_c    <= 0;
            per_o   <= 0;
            sw_o    <= 0;
            for (int k = 0; k < 3; k++) begin
                hi_c[k] <= 0;
                lo_c[k] <= 0;
                hi_o[k] <= 0;
                lo_o[k] <= 0;
            end
        end else begin
            sync_q  <= sync_i;
            meas_o  <= rise;
            // A gate driver pair switched on together shorts the link.
            shoot_o <= shoot_o | (|(high_i & low_i));
            per_c   <= rise ? 1 : per_c + 1;
            sw_c    <= sync_i ? sw_c + 1 : 0;
            if (sync_q && !sync_i) begin
                sw_o <= sw_c;
            end
            if (rise) begin
                per_o <= per_c;
            end
            for (int k = 0; k < 3; k++) begin
                hi_c[k] <= rise ? int'(high_i[k]) : hi_c[k] + int'(high_i[k]);
                lo_c[k] <= rise ? int'(low_i[k]) : lo_c[k] + int'(low_i[k]);
                if (rise) begin
                    hi_o[k] <= hi_c[k];
                    lo_o[k] <= lo_c[k];
                end
            end
        end
    end
endmodule : tptu_gate_model
`default_nettype wire

// ==== verif/three_phase_pwm_timing_unit_tb.sv ====
// Self-checking bench for the three-phase PWM timing unit.
`timescale 1ns/1ns
`default_nettype none
module three_phase_pwm_timing_unit_tb
    import tptu_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic [2:0]  high;
    logic [2:0]  low;
    logic [8:0]  oc;
    logic        sync;
    logic        sh;
    logic        meas;
    logic        shoot;
    int          per;
    int          sw;
    int          hi[3];
    int          lo[3];
    int          regs[16];
    int          ra[4] = '{1, 2, 3, 9};
    int          oc_cur;
    int          seed = 63;
    int          num_errors = 0;
    int          cmp_count = 0;

    always #4 clk = ~clk;

    tptu_timing_unit uut (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .high_o(high), .low_o(low),
        .out_ctrl_o(oc), .sync_o(sync), .second_half_o(sh));

    tptu_gate_model gate (.clk_i(clk), .rst_i(rst), .high_i(high), .low_i(low),
        .sync_i(sync), .meas_o(meas), .per_o(per), .hi_o(hi), .lo_o(lo),
        .sw_o(sw), .shoot_o(shoot));

    // ==========================================================
    // Reporting and bus tasks.
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    function automatic int msk(input int a);
        case (a)
            1: return 32'h3ff;
            3: return 32'hff;
            9: return 32'h1ff;
            0, 2, 4, 5, 6, 7: return 32'hffff;
            default: return 0;
        endcase
    endfunction : msk

    task automatic wr_reg(input int a, input int d);
        @(posedge clk);
        addr  <= a[3:0];
        wdata <= d[15:0];
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        regs[a] = d & msk(a);
    endtask : wr_reg

    task automatic rd_chk(input int a, input int e);
        @(posedge clk);
        addr <= a[3:0];
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata, e);
    endtask : rd_chk

    task automatic wait_meas(input int n);
        int t;
        for (int i = 0; i < n; i++) begin
            t = 0;
            do begin
                @(posedge clk);
                #1;
                t++;
            end while (meas !== 1'b1 && t < 1000);
            if (t >= 1000) begin
                num_errors++;
                $display("[FAIL] %0t no sync pulse", $time);
                conclude();
            end
        end
        #1;
    endtask : wait_meas

    // Compares one measured period with the expected on-times.
    task automatic check_period();
        int hv;
        int lv;
        check(per, 2 * regs[0]);
        check(sw, regs[3] + 1);
        for (int k = 0; k < 3; k++) begin
            hv = regs[4 + k] - regs[1];
            lv = regs[0] - regs[4 + k] - regs[1];
            if (hv < regs[2]) begin
                check(hi[k], 0);
            end else if (lv < regs[2]) begin
                check(lo[k], 0);
            end else begin
                check(hi[k], 2 * hv);
                check(lo[k], 2 * lv);
            end
        end
    endtask : check_period

    // ==========================================================
    // Main sequence.
    initial begin
        int   hp;
        int   dt;
        int   hs;
        logic prev;
        for (int i = 0; i < 16; i++) begin
            regs[i] = 0;
        end
        regs[3] = 32'h27;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(3, 32'h27);
        rd_chk(7, 0);
        for (int a = 8; a < 16; a++) begin
            if (a != 9) begin
                wr_reg(a, $random(seed));
                rd_chk(a, 0);
            end
        end
        foreach (ra[i]) begin
            wr_reg(ra[i], $random(seed));
            rd_chk(ra[i], regs[ra[i]]);
        end
        oc_cur = regs[9];
        check(oc, oc_cur);
        wr_reg(1, 2);
        wr_reg(2, 0);
        wr_reg(3, 32'h27);
        wr_reg(0, 32'hffff);
        rd_chk(0, 32'hffff);
        wr_reg(0, 60);
        wr_reg(4, 20);
        wr_reg(5, 45);
        repeat (30) @(posedge clk);
        #1;
        check({sync, high, low}, 0);
        wr_reg(6, 30);
        wait_meas(3);
        check_period();
        for (int i = 0; i < 4; i++) begin
            hp = 40 + ($random(seed) & 32'h1f);
            dt = (i == 0) ? 0 : ($random(seed) & 32'h7);
            wr_reg(0, hp);
            wr_reg(1, dt);
            wr_reg(3, (i == 0) ? 0 : ($random(seed) & 32'hf));
            for (int k = 0; k < 3; k++) begin
                wr_reg(4 + k, dt + 1 + (($random(seed) & 32'hff) % (hp - 2 * dt - 1)));
            end
            wait_meas(4);
            check_period();
        end
        wr_reg(0, 60);
        wr_reg(1, 2);
        wr_reg(2, 10);
        wr_reg(4, 11);
        wr_reg(5, 12);
        wr_reg(6, 50);
        wait_meas(4);
        check_period();
        wr_reg(9, $random(seed));
        repeat (3) @(posedge clk);
        #1;
        check(oc, oc_cur);
        wait_meas(1);
        oc_cur = regs[9];
        check(oc, oc_cur);
        wr_reg(2, 0);
        wr_reg(7, 32'h40);
        rd_chk(7, 32'h40);
        wait_meas(3);
        prev = sh;
        hs = 0;
        for (int i = 0; i < 4; i++) begin
            wait_meas(1);
            check(per, regs[0]);
            check(sh, !prev);
            prev = sh;
            hs += hi[0];
        end
        check(hs, 4 * (regs[4] - regs[1]));
        wr_reg(7, 0);
        wait_meas(3);
        check(sh, 0);
        check(per, 2 * regs[0]);
        check(shoot, 0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({sync, high, low, oc}, 0);
        @(posedge clk);
        rst <= 1'b0;
        rd_chk(7, 0);
        rd_chk(3, 32'h27);
        conclude();
    end
endmodule : three_phase_pwm_timing_unit_tb
`default_nettype wire
